// ==== cdp_cache.sv ====
`timescale 1ns/100ps
`include "cdp_defines.svh"
module cdp_cache #(
	parameter logic [`CDP_ADDR_W-1:0] MAINT_ADDR = 22'h3FFF00,
	parameter logic [`CDP_ADDR_W-1:0] LTC_ADDR = 22'h3FFF04
) (
	input wire logic sys_clk_in,
	input wire logic rst_n_in,
	input wire logic [`CDP_AVS_AW-1:0] avs_address_in,
	input wire logic avs_read_in,
	input wire logic avs_write_in,
	input wire logic [31:0] avs_writedata_in,
	input wire logic [3:0] avs_byteenable_in,
	output logic [31:0] avs_readdata_out,
	output logic avs_waitrequest_out,
	input wire logic [`CDP_ADDR_W-1:0] bbus_addr_in,
	input wire logic addr_strobe_in,
	input wire logic [1:0] sel_code_in,
	output logic [`CDP_ADDR_W-1:0] bbus_out,
	output logic bbus_oe_out,
	output logic byte_select_out,
	input wire logic update_in,
	input wire logic check_in,
	input wire logic flush_step_strobe_in,
	input wire logic stretch_control_strobe_n_in,
	input wire logic low_byte_select_n_in,
	input wire logic high_byte_select_n_in,
	input wire logic tag_select_n_in,
	input wire logic ram_write_en_n_in,
	input wire logic [15:0] data_in,
	output logic [15:0] data_out,
	output logic [`CDP_TAG_BUS_W-1:0] tag_bus_out,
	input wire logic [3:0] transaction_type_code_in,
	input wire logic [1:0] bank_select_code_in,
	input wire logic cache_bypass_in,
	input wire logic bus_event_n_in,
	input wire logic event_disable_jumper_in,
	input wire logic clear_event_decode_n_in,
	input wire logic module_initialise_n_in,
	output logic event_enable_out,
	output logic processor_event_request_n_out,
	output logic flush_in_progress_out,
	output logic write_wrong_parity_out,
	output logic predicted_tag_parity_out,
	output logic parity_error_n_out,
	output logic abort_n_out,
	output logic general_write_strobe_n_out,
	output logic io_page_select_out,
	output logic system_register_addressed_out,
	output logic [1:0] byte_parity_ok_n_out,
	output logic hit_out
);
	logic ack_r;
	logic [15:0] ltc_r;
	logic [15:0] ccr_r;
	logic [`CDP_ADDR_W-1:0] addr_r;
	cdp_pkg::cdp_flush_state_t fl_state_r;
	logic [`CDP_IDX_W-1:0] fcnt_r;
	logic fdone_r;
	logic ev_r;
	logic ev_prev_r;
	cdp_pkg::cdp_err_t err_r;
	logic update_r;
	logic check_r;
	logic pred_par_r;
	logic [1:0] cs_r;
	logic [7:0] rd_byte_r [0:1];
	logic [1:0] rd_par_r;
	logic [1:0] byte_good;
	logic [1:0] byte_match;
	logic wr_fire;
	logic rd_take;
	logic flush_start;
	logic running;
	logic step;
	logic rx_event;
	logic ev_edge;
	logic ev_clear;
	logic [`CDP_IDX_W-1:0] idx;
	logic [`CDP_LBL_W-1:0] cur_label;
	logic tag_we;
	cdp_pkg::cdp_tag_word_t tag_wdata;
	cdp_pkg::cdp_tag_word_t tag_rdata;
	logic label_match;
	logic tag_self_bad;
	logic err_event;
	logic [15:0] stat_word;

	// register bus: one wait cycle, then completion
	assign avs_waitrequest_out = (avs_read_in | avs_write_in) & ~ack_r;
	assign wr_fire = avs_write_in & ack_r;
	assign rd_take = avs_read_in & ~ack_r;

	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			ack_r <= 1'b0;
		end else begin
			ack_r <= (avs_read_in | avs_write_in) & ~ack_r;
		end
	end

	assign stat_word = {11'h000, hit_out, err_r.abort, err_r.parity, ev_r, running};

	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			avs_readdata_out <= 32'h00000000;
		end else if (rd_take) begin
			unique case (avs_address_in)
				`CDP_LTC_OFS: avs_readdata_out <= {16'h0000, ltc_r};
				`CDP_CCR_OFS: avs_readdata_out <= {16'h0000, ccr_r};
				`CDP_STAT_OFS: avs_readdata_out <= {16'h0000, stat_word};
				default: avs_readdata_out <= 32'h00000000;
			endcase
		end
	end

	// line clock register
	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			ltc_r <= `CDP_LTC_RST;
		end else if (wr_fire && avs_address_in == `CDP_LTC_OFS) begin
			if (avs_byteenable_in[0]) begin
				ltc_r[7:0] <= avs_writedata_in[7:0];
			end
			if (avs_byteenable_in[1]) begin
				ltc_r[15:8] <= avs_writedata_in[15:8];
			end
		end
	end
	assign event_enable_out = ltc_r[`CDP_LTC_EVEN_BIT];

	// cache control shadow
	assign flush_start = wr_fire && avs_address_in == `CDP_CCR_OFS && avs_byteenable_in[1] &&
		avs_writedata_in[`CDP_CCR_FLUSH_BIT] && !ccr_r[`CDP_CCR_FLUSH_BIT];

	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			ccr_r <= `CDP_CCR_RST;
		end else if (wr_fire && avs_address_in == `CDP_CCR_OFS) begin
			if (avs_byteenable_in[0]) begin
				ccr_r[7:0] <= avs_writedata_in[7:0];
			end
			if (avs_byteenable_in[1]) begin
				ccr_r[15:8] <= avs_writedata_in[15:8];
			end
		end else if (fdone_r && stretch_control_strobe_n_in) begin
			ccr_r[`CDP_CCR_FLUSH_BIT] <= 1'b0;
		end
	end
	assign write_wrong_parity_out = ccr_r[`CDP_CCR_WWPD_BIT];

	// flush sequencing, starts at reset
	assign running = fl_state_r == cdp_pkg::CDP_FL_RUN;
	assign step = running & flush_step_strobe_in;
	assign flush_in_progress_out = running;

	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			fl_state_r <= cdp_pkg::CDP_FL_RUN;
		end else begin
			unique case (fl_state_r)
				cdp_pkg::CDP_FL_IDLE: begin
					if (flush_start) begin
						fl_state_r <= cdp_pkg::CDP_FL_RUN;
					end
				end
				cdp_pkg::CDP_FL_RUN: begin
					if (step && fcnt_r == `CDP_CNT_MAX && !flush_start) begin
						fl_state_r <= cdp_pkg::CDP_FL_IDLE;
					end
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			fcnt_r <= `CDP_CNT_ZERO;
		end else if (flush_start) begin
			fcnt_r <= `CDP_CNT_ZERO;
		end else if (step) begin
			fcnt_r <= fcnt_r + 12'h001;
		end
	end

	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			fdone_r <= 1'b0;
		end else if (flush_start) begin
			fdone_r <= 1'b0;
		end else if (step && fcnt_r == `CDP_CNT_MAX) begin
			fdone_r <= 1'b1;
		end
	end

	// event flip-flop, set wins over clear
	assign rx_event = ~bus_event_n_in & ~event_disable_jumper_in;
	assign ev_edge = rx_event & ~ev_prev_r;
	assign ev_clear = ~clear_event_decode_n_in | ~module_initialise_n_in;

	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			ev_prev_r <= 1'b0;
			ev_r <= 1'b0;
		end else begin
			ev_prev_r <= rx_event;
			if (ev_edge) begin
				ev_r <= 1'b1;
			end else if (ev_clear) begin
				ev_r <= 1'b0;
			end
		end
	end
	assign processor_event_request_n_out = ~(ev_r & event_enable_out);

	// address register
	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			addr_r <= 22'h000000;
		end else if (addr_strobe_in) begin
			addr_r <= bbus_addr_in;
		end
	end
	assign byte_select_out = addr_r[0];
	assign cur_label = addr_r[`CDP_LBL_MSB:`CDP_LBL_LSB];
	assign idx = running ? fcnt_r : addr_r[`CDP_IDX_MSB:`CDP_IDX_LSB];

	// bus source select and decoded outputs
	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			bbus_out <= 22'h000000;
			bbus_oe_out <= 1'b0;
			tag_bus_out <= 11'h000;
			predicted_tag_parity_out <= 1'b0;
			general_write_strobe_n_out <= 1'b1;
			io_page_select_out <= 1'b0;
			system_register_addressed_out <= 1'b0;
		end else begin
			bbus_oe_out <= sel_code_in != `CDP_SEL_OFF;
			unique case (sel_code_in)
				`CDP_SEL_OFF: bbus_out <= 22'h000000;
				`CDP_SEL_ADDR: bbus_out <= addr_r;
				`CDP_SEL_ERR: bbus_out <= {19'h00000, err_r.abort, err_r.parity, ev_r};
				`CDP_SEL_FLUSH: bbus_out <= {9'h000, fcnt_r, 1'b0};
			endcase
			tag_bus_out <= update_in ? tag_wdata[`CDP_TAG_BUS_W-1:0] : 11'h000;
			predicted_tag_parity_out <= ^{cur_label, 1'b1};
			general_write_strobe_n_out <= transaction_type_code_in != `CDP_TT_GP_WRITE;
			io_page_select_out <= bank_select_code_in == `CDP_BS_IO || cache_bypass_in;
			system_register_addressed_out <= addr_r == MAINT_ADDR || addr_r == LTC_ADDR;
		end
	end

	// tag store: flush clears valid, update writes label
	assign tag_we = running ? step : (~tag_select_n_in & ~ram_write_en_n_in & update_in);
	always_comb begin
		tag_wdata = '0;
		if (!running) begin
			tag_wdata.label = cur_label;
			tag_wdata.valid = 1'b1;
			tag_wdata.parity = ^{cur_label, 1'b1} ^ ccr_r[`CDP_CCR_WWPT_BIT];
		end
	end

	cdp_tag_ram #(
		.IDX_W(`CDP_IDX_W)
	) u_tag_ram (
		.sys_clk_in(sys_clk_in),
		.we_in(tag_we),
		.idx_in(idx),
		.wdata_in(tag_wdata),
		.rdata_out(tag_rdata)
	);

	// data and parity store, one lane per byte
	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : g_byte
			logic [7:0] dmem [0:(1<<`CDP_IDX_W)-1];
			logic pmem [0:(1<<`CDP_IDX_W)-1];
			logic cs;
			logic gen_par;
			logic odd;
			assign odd = g == 1;
			assign cs = (g == 0) ? ~low_byte_select_n_in : ~high_byte_select_n_in;
			assign gen_par = ^data_in[8*g+7:8*g] ^ odd;
			always_ff @(posedge sys_clk_in) begin
				if (cs && !ram_write_en_n_in && update_in && !running) begin
					dmem[idx] <= data_in[8*g+7:8*g];
					pmem[idx] <= gen_par ^ write_wrong_parity_out;
				end
				rd_byte_r[g] <= dmem[idx];
				rd_par_r[g] <= pmem[idx];
			end
			assign byte_match[g] = rd_par_r[g] == (^rd_byte_r[g] ^ odd);
			assign byte_good[g] = ~cs_r[g] | byte_match[g];
			assign byte_parity_ok_n_out[g] = ~(cs_r[g] & byte_match[g] & ~update_r);
		end
	endgenerate
	assign data_out = {rd_byte_r[1], rd_byte_r[0]};

	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			cs_r <= 2'h0;
			update_r <= 1'b0;
			check_r <= 1'b0;
			pred_par_r <= 1'b0;
		end else begin
			cs_r <= {~high_byte_select_n_in, ~low_byte_select_n_in};
			update_r <= update_in;
			check_r <= check_in;
			pred_par_r <= ^{cur_label, 1'b1};
		end
	end

	// hit and parity error reporting
	assign label_match = tag_rdata.label == cur_label;
	assign tag_self_bad = tag_rdata.parity != ^{tag_rdata.label, tag_rdata.valid};
	assign hit_out = label_match & tag_rdata.valid & (tag_rdata.parity == pred_par_r) &
		(&byte_good) & ~running;
	assign err_event = check_r & ~update_r & tag_rdata.valid &
		(tag_self_bad | (label_match & ~(&byte_good)));

	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			err_r <= '0;
		end else if (err_event) begin
			err_r.abort <= ccr_r[`CDP_CCR_PABT_BIT];
			err_r.parity <= ccr_r[`CDP_CCR_PABT_BIT] | ~ccr_r[`CDP_CCR_NOINT_BIT];
		end else if (addr_strobe_in) begin
			err_r <= '0;
		end
	end
	assign parity_error_n_out = ~err_r.parity;
	assign abort_n_out = ~err_r.abort;

	event_enable_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
		wr_fire && avs_address_in == `CDP_LTC_OFS && avs_byteenable_in[0]
		|=> event_enable_out == $past(avs_writedata_in[`CDP_LTC_EVEN_BIT]))
		else $error("event enable not following line clock write");
	event_set_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
		ev_edge |=> ev_r ##0 (processor_event_request_n_out == !event_enable_out))
		else $error("event edge did not request");
	event_clear_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
		ev_clear && !ev_edge |=> !ev_r && processor_event_request_n_out)
		else $error("event flop not cleared");
	flush_begin_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
		flush_start |=> flush_in_progress_out && fcnt_r == `CDP_CNT_ZERO)
		else $error("flush did not start from zero");
	flush_step_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
		step && !flush_start |=> fcnt_r == $past(fcnt_r) + 12'h001)
		else $error("flush counter did not advance");
	flush_end_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
		step && fcnt_r == `CDP_CNT_MAX && !flush_start |=> !flush_in_progress_out && fdone_r)
		else $error("flush did not end on overflow");
	addr_latch_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
		addr_strobe_in |=> addr_r == $past(bbus_addr_in) && byte_select_out == $past(bbus_addr_in[0]))
		else $error("address not latched");
	bus_select_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
		sel_code_in == `CDP_SEL_ADDR |=> bbus_oe_out && bbus_out == $past(addr_r))
		else $error("address not driven back");
	tag_drive_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
		update_in && !running |=> tag_bus_out[`CDP_LBL_W-1:0] == $past(cur_label))
		else $error("label missing on tag bus");
	flush_clear_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
		fdone_r && stretch_control_strobe_n_in && !wr_fire |=> !ccr_r[`CDP_CCR_FLUSH_BIT])
		else $error("flush bit did not clear");
	err_code_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
		err_event && ccr_r[`CDP_CCR_PABT_BIT] |=> !abort_n_out && !parity_error_n_out)
		else $error("parity abort not encoded");
	hit_clean_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
		hit_out |-> !err_event && !running && tag_rdata.valid)
		else $error("hit with failed check");
endmodule // cdp_cache

// ==== cdp_defines.svh ====
`ifndef CDP_DEFINES_SVH
`define CDP_DEFINES_SVH
// What this block does
// - line clock register rw, bit 06 enables events
// - event flop from received event, gated, requests processor
// - event flop cleared by clear decode or initialise
// - power-up or control bit 08 starts flush
// - flush counter indexes cache, one step per strobe
// - 12-bit counter overflow ends flush in progress
// - address register latches bus address, byte select
// - select code drives latched address back out
// - update strobe drives label bits onto tag bus
// - control bit 06 drives write wrong parity
// - predicted parity over label bits of address
// - parity and abort outputs encode error action
// - general write strobe on general write type
// - io page select on io bank or bypass
// - system register addressed for maintenance or clock
// - low even, high odd, tag even parity stored
// - byte read on select, written with write enable
// - wrong parity inverts generated data parity bit
// - generate with update, otherwise check and report ok
// - tag ram 4K by 12, label valid parity
// - hit needs match, valid, tag and byte parity
// - select code picks bus source, 00 tristates
// - flush bit self clears after overflow, stretch negated

`define CDP_ADDR_W 22
`define CDP_IDX_W 12
`define CDP_LBL_W 9
`define CDP_IDX_LSB 1
`define CDP_IDX_MSB 12
`define CDP_LBL_LSB 13
`define CDP_LBL_MSB 21
`define CDP_TAG_BUS_W 11
`define CDP_CNT_MAX 12'hFFF
`define CDP_CNT_ZERO 12'h000

`define CDP_AVS_AW 4
`define CDP_LTC_OFS 4'h0
`define CDP_CCR_OFS 4'h4
`define CDP_STAT_OFS 4'h8
`define CDP_LTC_RST 16'h0000
`define CDP_CCR_RST 16'h0000

`define CDP_LTC_EVEN_BIT 6
`define CDP_CCR_NOINT_BIT 0
`define CDP_CCR_WWPD_BIT 6
`define CDP_CCR_PABT_BIT 7
`define CDP_CCR_FLUSH_BIT 8
`define CDP_CCR_WWPT_BIT 10

`define CDP_SEL_OFF 2'h0
`define CDP_SEL_ADDR 2'h1
`define CDP_SEL_ERR 2'h2
`define CDP_SEL_FLUSH 2'h3

`define CDP_TT_GP_WRITE 4'hA
`define CDP_BS_IO 2'h3

`define CDP_CLK_MHZ 125
`define CDP_FLUSH_TIME_NS 1300
`define CDP_FLUSH_MAX_CYC ((`CDP_FLUSH_TIME_NS * `CDP_CLK_MHZ) / 1000)
`endif

// ==== cdp_pkg.sv ====
`include "cdp_defines.svh"
package cdp_pkg;
	typedef struct packed {
		logic unused;
		logic parity;
		logic valid;
		logic [`CDP_LBL_W-1:0] label;
	} cdp_tag_word_t;

	typedef struct packed {
		logic abort;
		logic parity;
	} cdp_err_t;

	typedef enum logic [0:0] {
		CDP_FL_IDLE = 1'b0,
		CDP_FL_RUN = 1'b1
	} cdp_flush_state_t;
endpackage

// ==== cdp_seq_model.sv ====
`timescale 1ns/100ps
module cdp_seq_model (
	input wire logic sys_clk_in,
	input wire logic rst_n_in,
	input wire logic flush_in_progress_in,
	output logic flush_step_strobe_out
);
	// one step pulse every other cycle while flushing, quiet otherwise
	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			flush_step_strobe_out <= 1'b0;
		end else begin
			flush_step_strobe_out <= flush_in_progress_in & ~flush_step_strobe_out;
		end
	end
endmodule // cdp_seq_model

// ==== cdp_tag_ram.sv ====
`timescale 1ns/100ps
`include "cdp_defines.svh"
module cdp_tag_ram #(
	parameter int IDX_W = `CDP_IDX_W
) (
	input wire logic sys_clk_in,
	input wire logic we_in,
	input wire logic [IDX_W-1:0] idx_in,
	input wire cdp_pkg::cdp_tag_word_t wdata_in,
	output cdp_pkg::cdp_tag_word_t rdata_out
);
	cdp_pkg::cdp_tag_word_t mem [0:(1<<IDX_W)-1];

	// one word per index, registered read
	always_ff @(posedge sys_clk_in) begin
		if (we_in) begin
			mem[idx_in] <= wdata_in;
		end
		rdata_out <= mem[idx_in];
	end
endmodule // cdp_tag_ram

// ==== tb_direct_mapped_cache_parity_flush.sv ====
`timescale 1ns/100ps
module tb_direct_mapped_cache_parity_flush;
	logic sys_clk_in, rst_n_in, avs_read_in, avs_write_in, addr_strobe_in, update_in, check_in;
	logic stretch_control_strobe_n_in, low_byte_select_n_in, high_byte_select_n_in;
	logic tag_select_n_in, ram_write_en_n_in, cache_bypass_in, bus_event_n_in;
	logic event_disable_jumper_in, clear_event_decode_n_in, module_initialise_n_in;
	logic flush_step_strobe_in, avs_waitrequest_out, bbus_oe_out, byte_select_out;
	logic event_enable_out, processor_event_request_n_out, flush_in_progress_out;
	logic write_wrong_parity_out, predicted_tag_parity_out, parity_error_n_out, abort_n_out;
	logic general_write_strobe_n_out, io_page_select_out, system_register_addressed_out, hit_out;
	logic [3:0] avs_address_in, avs_byteenable_in, transaction_type_code_in;
	logic [31:0] avs_writedata_in, avs_readdata_out, rd;
	logic [21:0] bbus_addr_in, bbus_out;
	logic [21:0] addr_tbl [3];
	logic [1:0] sel_code_in, bank_select_code_in, byte_parity_ok_n_out;
	logic [15:0] data_in, data_out;
	logic [10:0] tag_bus_out;
	int num_errors, n_tests, n, cnt;
	logic tag_flip;
	localparam logic [21:0] A = 22'h1B3456;
	localparam logic [15:0] D = 16'h81C3;

	cdp_cache dut (.sys_clk_in, .rst_n_in, .avs_address_in, .avs_read_in, .avs_write_in,
		.avs_writedata_in, .avs_byteenable_in, .avs_readdata_out, .avs_waitrequest_out,
		.bbus_addr_in, .addr_strobe_in, .sel_code_in, .bbus_out, .bbus_oe_out, .byte_select_out,
		.update_in, .check_in, .flush_step_strobe_in, .stretch_control_strobe_n_in,
		.low_byte_select_n_in, .high_byte_select_n_in, .tag_select_n_in, .ram_write_en_n_in,
		.data_in, .data_out, .tag_bus_out, .transaction_type_code_in, .bank_select_code_in,
		.cache_bypass_in, .bus_event_n_in, .event_disable_jumper_in, .clear_event_decode_n_in,
		.module_initialise_n_in, .event_enable_out, .processor_event_request_n_out,
		.flush_in_progress_out, .write_wrong_parity_out, .predicted_tag_parity_out,
		.parity_error_n_out, .abort_n_out, .general_write_strobe_n_out, .io_page_select_out,
		.system_register_addressed_out, .byte_parity_ok_n_out, .hit_out);
	cdp_seq_model seq (.sys_clk_in, .rst_n_in, .flush_in_progress_in(flush_in_progress_out),
		.flush_step_strobe_out(flush_step_strobe_in));

	task stop_test;
		begin
			$display("errors %0d checks %0d", num_errors, n_tests);
			if (num_errors == 0 && n_tests > 0) begin
				$display("Regression OK");
			end else begin
				$display("Regression broken");
			end
			$finish;
		end
	endtask
	task chk(input logic [31:0] g, input logic [31:0] e, input string m);
		begin
			n_tests++;
			if (g !== e) begin
				num_errors++;
				$display("FAIL %0t %s got %h exp %h", $time, m, g, e);
			end
		end
	endtask
	task cyc(input int k);
		repeat (k) @(posedge sys_clk_in);
	endtask
	task avs(input logic w, input logic [3:0] a, input logic [31:0] d);
		begin
			@(posedge sys_clk_in);
			avs_address_in <= a;
			avs_writedata_in <= d;
			avs_write_in <= w;
			avs_read_in <= !w;
			n = 0;
			do begin
				@(posedge sys_clk_in);
				n++;
			end while (avs_waitrequest_out !== 1'b0 && n < 20);
			rd = avs_readdata_out;
			avs_write_in <= 1'b0;
			avs_read_in <= 1'b0;
			if (n >= 20) begin
				num_errors++;
				$display("FAIL %0t bus timeout", $time);
				stop_test;
			end
		end
	endtask
	task sel_ram(input logic s, input logic w);
		begin
			low_byte_select_n_in <= s;
			high_byte_select_n_in <= s;
			tag_select_n_in <= s;
			ram_write_en_n_in <= w;
		end
	endtask
	task latch(input logic [21:0] a);
		begin
			@(posedge sys_clk_in);
			bbus_addr_in <= a;
			addr_strobe_in <= 1'b1;
			@(posedge sys_clk_in);
			addr_strobe_in <= 1'b0;
		end
	endtask
	task cw(input logic [21:0] a, input logic [15:0] d);
		begin
			latch(a);
			update_in <= 1'b1;
			data_in <= d;
			sel_ram(1'b0, 1'b0);
			@(posedge sys_clk_in);
			update_in <= 1'b0;
			sel_ram(1'b1, 1'b1);
			@(posedge sys_clk_in);
			chk(tag_bus_out, {^{a[21:13], 1'b1} ^ tag_flip, 1'b1, a[21:13]}, "tag bus");
		end
	endtask
	task cr(input logic [21:0] a);
		begin
			latch(a);
			check_in <= 1'b1;
			sel_ram(1'b0, 1'b1);
			@(posedge sys_clk_in);
			check_in <= 1'b0;
			sel_ram(1'b1, 1'b1);
			@(posedge sys_clk_in);
			chk(predicted_tag_parity_out, ^{a[21:13], 1'b1}, "predicted parity");
			chk(byte_select_out, a[0], "byte select");
		end
	endtask
	task flush_run;
		begin
			n = 0;
			cnt = 0;
			do begin
				@(posedge sys_clk_in);
				n++;
				if (flush_step_strobe_in === 1'b1 && flush_in_progress_out === 1'b1) cnt++;
			end while (flush_in_progress_out === 1'b1 && n < 20000);
			if (n >= 20000) begin
				num_errors++;
				$display("FAIL %0t flush timeout", $time);
				stop_test;
			end
			chk(cnt, 4096, "flush steps");
		end
	endtask
	task errs(input logic p, input logic ab, input string m);
		begin
			@(posedge sys_clk_in);
			chk(parity_error_n_out, p, m);
			chk(abort_n_out, ab, m);
		end
	endtask

	initial begin
		sys_clk_in = 1'b0;
		forever #4 sys_clk_in = ~sys_clk_in;
	end
	initial begin
		repeat (100000) @(posedge sys_clk_in);
		num_errors++;
		$display("FAIL %0t run timeout", $time);
		stop_test;
	end
	initial begin
		num_errors = 0;
		n_tests = 0;
		rst_n_in = 1'b0;
		{avs_read_in, avs_write_in, addr_strobe_in, update_in, check_in, cache_bypass_in} = '0;
		{low_byte_select_n_in, high_byte_select_n_in, tag_select_n_in, ram_write_en_n_in} = '1;
		{stretch_control_strobe_n_in, bus_event_n_in, clear_event_decode_n_in} = '1;
		module_initialise_n_in = 1'b1;
		event_disable_jumper_in = 1'b0;
		avs_address_in = 4'h0;
		avs_byteenable_in = 4'h3;
		avs_writedata_in = 32'h0;
		transaction_type_code_in = 4'h0;
		bank_select_code_in = 2'h0;
		sel_code_in = 2'h0;
		bbus_addr_in = 22'h0;
		data_in = 16'h0;
		tag_flip = 1'b0;
		addr_tbl = '{22'h3FFF00, 22'h3FFF04, 22'h000101};
		repeat (16) @(posedge sys_clk_in);
		rst_n_in <= 1'b1;
		chk(flush_in_progress_out, 1, "power-up flush");
		flush_run;
		sel_code_in <= 2'h3;
		cyc(2);
		chk(bbus_out[12:1], 0, "counter wrapped");
		chk(bbus_oe_out, 1, "bus driven");
		avs(1'b1, 4'h0, 32'h40);
		avs(1'b0, 4'h0, 32'h0);
		chk(rd, 32'h40, "line clock readback");
		chk(event_enable_out, 1, "event enable");
		avs(1'b1, 4'hC, 32'hFFFF);
		avs(1'b0, 4'hC, 32'h0);
		chk(rd, 0, "unmapped read");
		bus_event_n_in <= 1'b0;
		cyc(3);
		chk(processor_event_request_n_out, 0, "event request");
		bus_event_n_in <= 1'b1;
		clear_event_decode_n_in <= 1'b0;
		cyc(1);
		clear_event_decode_n_in <= 1'b1;
		cyc(1);
		chk(processor_event_request_n_out, 1, "event cleared");
		bus_event_n_in <= 1'b0;
		cyc(3);
		chk(processor_event_request_n_out, 0, "event again");
		bus_event_n_in <= 1'b1;
		module_initialise_n_in <= 1'b0;
		cyc(1);
		module_initialise_n_in <= 1'b1;
		event_disable_jumper_in <= 1'b1;
		bus_event_n_in <= 1'b0;
		cyc(3);
		chk(processor_event_request_n_out, 1, "init clears, jumper blocks");
		event_disable_jumper_in <= 1'b0;
		bus_event_n_in <= 1'b1;
		sel_code_in <= 2'h0;
		cw(A, D);
		cr(A);
		chk(data_out, D, "read data");
		chk(hit_out, 1, "hit");
		chk(byte_parity_ok_n_out, 0, "parity ok");
		errs(1'b1, 1'b1, "no error");
		cr(A ^ 22'h200000);
		chk(hit_out, 0, "label miss");
		avs(1'b1, 4'h4, 32'h40);
		cyc(2);
		chk(write_wrong_parity_out, 1, "wrong parity out");
		cw(A, D);
		avs(1'b1, 4'h4, 32'h0);
		cr(A);
		chk(hit_out, 0, "bad parity miss");
		chk(byte_parity_ok_n_out, 2'h3, "parity bad");
		errs(1'b0, 1'b1, "parity only");
		avs(1'b1, 4'h4, 32'h80);
		cr(A);
		errs(1'b0, 1'b0, "parity abort");
		avs(1'b1, 4'h4, 32'h01);
		cr(A);
		errs(1'b1, 1'b1, "parity quiet");
		avs(1'b1, 4'h4, 32'h400);
		tag_flip = 1'b1;
		cw(A, D);
		avs(1'b1, 4'h4, 32'h0);
		tag_flip = 1'b0;
		cr(A);
		chk(hit_out, 0, "tag parity miss");
		errs(1'b0, 1'b1, "tag parity");
		cw(A, D);
		transaction_type_code_in <= 4'hA;
		bank_select_code_in <= 2'h3;
		cyc(2);
		chk(general_write_strobe_n_out, 0, "gp write");
		chk(io_page_select_out, 1, "io bank");
		transaction_type_code_in <= 4'h0;
		bank_select_code_in <= 2'h0;
		cache_bypass_in <= 1'b1;
		cyc(2);
		chk(general_write_strobe_n_out, 1, "gp idle");
		chk(io_page_select_out, 1, "bypass");
		cache_bypass_in <= 1'b0;
		cyc(2);
		chk(io_page_select_out, 0, "io idle");
		for (int i = 0; i < 3; i++) begin
			latch(addr_tbl[i]);
			sel_code_in <= 2'h1;
			cyc(2);
			chk(system_register_addressed_out, i < 2, "system register");
			chk(bbus_out, addr_tbl[i], "address out");
			chk(byte_select_out, addr_tbl[i][0], "byte select");
			sel_code_in <= 2'h0;
			cyc(2);
			chk(bbus_oe_out, 0, "tristate");
		end
		sel_code_in <= 2'h2;
		bus_event_n_in <= 1'b0;
		cyc(3);
		chk({bbus_oe_out, bbus_out[2:0]}, 4'h9, "error register");
		bus_event_n_in <= 1'b1;
		sel_code_in <= 2'h0;
		stretch_control_strobe_n_in <= 1'b0;
		avs(1'b1, 4'h4, 32'h100);
		cyc(1);
		chk(flush_in_progress_out, 1, "flush restart");
		flush_run;
		cyc(4);
		avs(1'b0, 4'h4, 32'h0);
		chk(rd, 32'h100, "flush bit held");
		stretch_control_strobe_n_in <= 1'b1;
		cyc(2);
		avs(1'b0, 4'h4, 32'h0);
		chk(rd, 0, "flush bit cleared");
		cr(A);
		chk(hit_out, 0, "flushed miss");
		stop_test;
	end
endmodule // tb_direct_mapped_cache_parity_flush
